// >>> rtl/ispc_pixel_port.sv
// Image sample port with auxiliary coefficient output
// Function
// - One sample per clock at most, all synchronous to the single clock.
// - Encode: bus, sync, end-of-scan in, halt out; decode: reversed.
// - Block modes: one-cycle sync just before each 64-sample burst.
// - Preview and lossless: sync in the cycle before every sample.
// - Block encoding captures only the top eight sample bits.
// - Halt rises at three of four buffers full; partner stops after block.
// - Halt 24 clocks before last sample stops after this block, else next.
// - Decoded output blocks may be separated by any gap.
// - Preview end-of-scan within 64 clocks after final sample.
// - Preview sample is block DC on upper eleven bits, bit zero low.
// - Lossless precision below 12 uses top bits; decode zeroes the rest.
// - Lossless samples may be back to back or spaced by idles.
// - Lossless decode end-of-scan within 64 clocks after final sample.
// - Lossless decode drops sync one clock after sampling halt.
// - Block modes show coefficients, sync marks block start, DC first.
// - Encode coefficients appear 81 clocks after input; gaps carried.
// - Decode coefficients lead sample output by 80 clocks; gaps carried.
`timescale 1ns/1ps
module ispc_pixel_port (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire ispc_pkg::ispc_mode_t mode_i,
  input wire logic [3:0] precision_i,
  input wire logic [ispc_pkg::PIX_W-1:0] pixel_i,
  output logic [ispc_pkg::PIX_W-1:0] pixel_o,
  output logic pixel_oe_n_o,
  input wire logic block_sync_i,
  output logic block_sync_o,
  output logic block_sync_oe_n_o,
  input wire logic end_of_scan_i,
  output logic end_of_scan_o,
  output logic end_of_scan_oe_n_o,
  input wire logic halt_i,
  output logic halt_o,
  output logic halt_oe_n_o,
  input wire logic [2:0] bufs_used_i,
  output logic [ispc_pkg::PIX_W-1:0] enc_data_o,
  output logic enc_vld_o,
  output logic enc_eos_o,
  input wire logic [ispc_pkg::PIX_W-1:0] dec_sample_i,
  input wire logic dec_vld_i,
  input wire logic dec_last_i,
  output logic dec_take_o,
  output logic dec_hold_o,
  input wire logic [ispc_pkg::PIX_W-1:0] coefficient_bus_i,
  input wire logic coefficient_bus_sync_i,
  input wire logic coefficient_bus_vld_i,
  output logic [ispc_pkg::PIX_W-1:0] coefficient_bus_o,
  output logic coefficient_block_sync_o,
  output logic coefficient_vld_o
);
  import ispc_pkg::*;

  ispc_state_t state_r;
  ispc_state_t state_nxt;
  logic is_enc;
  logic is_dec;
  logic tap;
  logic have;
  logic start;
  logic accept;

  // Keep only the top p bits of a sample
  function automatic logic [PIX_W-1:0] prec_mask(
    input logic [PIX_W-1:0] d,
    input logic [3:0] p
  );
    logic [PIX_W-1:0] m;
    m = '1;
    if (p != 4'h0 && p < PREC_FULL)
    begin
      m = m << (PREC_FULL - p);
    end
    return d & m;
  endfunction

  // Next-state logic for every mode
  always_comb
  begin
    state_nxt = state_r;
    is_enc = (mode_i == MD_ENC_BL) || (mode_i == MD_ENC_LL);
    is_dec = (mode_i == MD_DEC_BL) || (mode_i == MD_DEC_PV)
      || (mode_i == MD_DEC_LL);
    tap = state_r.dly[DEC_TAP][PIX_W+1];
    have = tap || (state_r.pend != 3'h0);
    start = 1'b0;
    accept = 1'b0;
    // One-cycle strobes fall back to idle
    state_nxt.bsync = 1'b0;
    state_nxt.enc_vld = 1'b0;
    state_nxt.enc_eos = 1'b0;
    state_nxt.take = 1'b0;
    state_nxt.stgv = 1'b0;
    state_nxt.lastp = 1'b0;
    state_nxt.end_of_scan = state_r.lastp;
    // Pin direction follows the mode
    state_nxt.dec_oe_n = !is_dec;
    state_nxt.halt_oe_n = !is_enc;
    state_nxt.halt = is_enc && (bufs_used_i >= HALT_BUFS);
    state_nxt.hold = halt_i;
    state_nxt.sync_d = block_sync_i;
    // Coefficient delay line, one entry per clock
    state_nxt.dly = {state_r.dly[DLY_DEPTH-2:0], {coefficient_bus_sync_i, coefficient_bus_vld_i, coefficient_bus_i}};
    // Coefficient bus source
    state_nxt.coefficient_bus = '0;
    state_nxt.coefficient_block_sync = 1'b0;
    state_nxt.cvld = 1'b0;
    if (mode_i == MD_ENC_BL)
    begin
      state_nxt.coefficient_bus = state_r.dly[ENC_TAP][PIX_W-1:0];
      state_nxt.cvld = state_r.dly[ENC_TAP][PIX_W];
      state_nxt.coefficient_block_sync = state_r.dly[ENC_TAP][PIX_W+1];
    end
    else if (mode_i == MD_DEC_BL)
    begin
      state_nxt.coefficient_bus = coefficient_bus_i;
      state_nxt.cvld = coefficient_bus_vld_i;
      state_nxt.coefficient_block_sync = coefficient_bus_sync_i;
    end
    case (mode_i)
      MD_ENC_BL:
      begin
        // Wait for sync, then take a burst of 64 samples
        if (state_r.st == ST_IDLE)
        begin
          if (block_sync_i)
          begin
            state_nxt.st = ST_DATA;
            state_nxt.idx = 6'h00;
          end
        end
        else
        begin
          state_nxt.enc_vld = 1'b1;
          state_nxt.enc_data = '0;
          state_nxt.enc_data[PIX_W-1 -: BL_ENC_BITS] =
            pixel_i[PIX_W-1 -: BL_ENC_BITS];
          state_nxt.enc_eos = end_of_scan_i;
          state_nxt.idx = state_r.idx + 6'h01;
          if (state_r.idx == LAST_IDX)
          begin
            state_nxt.idx = 6'h00;
            if (!block_sync_i)
            begin
              state_nxt.st = ST_IDLE;
            end
          end
        end
      end
      MD_DEC_BL:
      begin
        if (state_r.st == ST_IDLE)
        begin
          start = have && (!halt_i || state_r.grant);
        end
        else
        begin
          // Put one decoded sample on the bus each clock
          state_nxt.pix = dec_sample_i;
          state_nxt.take = 1'b1;
          state_nxt.idx = state_r.idx + 6'h01;
          if (halt_i && (state_r.idx <= EARLY_IDX))
          begin
            state_nxt.early = 1'b1;
          end
          if (state_r.idx == LAST_IDX)
          begin
            state_nxt.lastp = dec_last_i;
            state_nxt.early = 1'b0;
            start = have && !(halt_i && state_r.early);
            if (!start)
            begin
              state_nxt.st = ST_IDLE;
              state_nxt.grant = halt_i && !state_r.early;
            end
          end
        end
        if (start)
        begin
          state_nxt.bsync = 1'b1;
          state_nxt.st = ST_DATA;
          state_nxt.idx = 6'h00;
          state_nxt.grant = 1'b0;
        end
        // Blocks whose coefficients have passed but not yet shown
        state_nxt.pend = 3'(state_r.pend + {2'h0, tap} - {2'h0, start});
      end
      MD_DEC_PV, MD_DEC_LL:
      begin
        // Sync one clock ahead of each sample, staged one clock
        accept = dec_vld_i && !state_r.hold;
        state_nxt.take = accept;
        state_nxt.bsync = accept;
        state_nxt.stgv = accept;
        state_nxt.stg_last = dec_last_i && accept;
        if (mode_i == MD_DEC_PV)
        begin
          state_nxt.stg = {dec_sample_i[PV_BITS-1:0], 1'b0};
        end
        else
        begin
          state_nxt.stg = prec_mask(dec_sample_i, precision_i);
        end
        if (state_r.stgv)
        begin
          state_nxt.pix = state_r.stg;
          state_nxt.lastp = state_r.stg_last;
        end
      end
      MD_ENC_LL:
      begin
        // Sample follows the clock that carried sync
        if (state_r.sync_d)
        begin
          state_nxt.enc_vld = 1'b1;
          state_nxt.enc_data = prec_mask(pixel_i, precision_i);
          state_nxt.enc_eos = end_of_scan_i;
        end
      end
      default:
      begin
        state_nxt.st = ST_IDLE;
        state_nxt.idx = 6'h00;
        state_nxt.early = 1'b0;
        state_nxt.grant = 1'b0;
        state_nxt.pend = 3'h0;
      end
    endcase
    if (mode_i != MD_DEC_BL)
    begin
      state_nxt.pend = 3'h0;
    end
  end

  // State register, undriven pins after reset
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      state_r <= '0;
      state_r.dec_oe_n <= 1'b1;
      state_r.halt_oe_n <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register
  assign pixel_o = state_r.pix;
  assign pixel_oe_n_o = state_r.dec_oe_n;
  assign block_sync_o = state_r.bsync;
  assign block_sync_oe_n_o = state_r.dec_oe_n;
  assign end_of_scan_o = state_r.end_of_scan;
  assign end_of_scan_oe_n_o = state_r.dec_oe_n;
  assign halt_o = state_r.halt;
  assign halt_oe_n_o = state_r.halt_oe_n;
  assign enc_data_o = state_r.enc_data;
  assign enc_vld_o = state_r.enc_vld;
  assign enc_eos_o = state_r.enc_eos;
  assign dec_take_o = state_r.take;
  assign dec_hold_o = state_r.hold;
  assign coefficient_bus_o = state_r.coefficient_bus;
  assign coefficient_block_sync_o = state_r.coefficient_block_sync;
  assign coefficient_vld_o = state_r.cvld;

  // Checks on the port behaviour
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_dir;
    (mode_i == MD_ENC_BL) && $stable(mode_i) |->
      !halt_oe_n_o && pixel_oe_n_o && block_sync_oe_n_o;
  endproperty
  a_dir: assert property (p_dir) else $error("Pin direction wrong in encode");

  property p_burst;
    (mode_i == MD_DEC_BL)[*2] ##0 block_sync_o |=>
      (dec_take_o && !block_sync_o)[*8];
  endproperty
  a_burst: assert property (p_burst) else $error("Block burst broken");

  property p_enc8;
    (mode_i == MD_ENC_BL) && enc_vld_o |->
      enc_data_o[PIX_W-BL_ENC_BITS-1:0] == '0;
  endproperty
  a_enc8: assert property (p_enc8) else $error("Low sample bits kept");

  property p_halt;
    (mode_i == MD_ENC_BL) && (bufs_used_i >= HALT_BUFS) |=> halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("Halt not raised");

  property p_early;
    (mode_i == MD_DEC_BL) && (state_r.st == ST_DATA)
      && (state_r.idx == LAST_IDX) && state_r.early && halt_i |=>
      !block_sync_o;
  endproperty
  a_early: assert property (p_early) else $error("Block after early halt");

  property p_pv;
    (mode_i == MD_DEC_PV)[*3] ##0 $past(block_sync_o) |->
      pixel_o[0] == 1'b0;
  endproperty
  a_pv: assert property (p_pv) else $error("Preview low bit set");

  property p_prec;
    (mode_i == MD_DEC_LL)[*3] ##0 (precision_i == 4'h8)[*3] ##0
      $past(block_sync_o) |-> pixel_o[3:0] == 4'h0;
  endproperty
  a_prec: assert property (p_prec) else $error("Unused bits not zero");

  property p_eos;
    (mode_i == MD_DEC_LL) && $past(state_r.stgv) && state_r.lastp |=>
      end_of_scan_o;
  endproperty
  a_eos: assert property (p_eos) else $error("End of scan late");

  property p_stop;
    (mode_i == MD_DEC_LL) && dec_hold_o |=> !block_sync_o;
  endproperty
  a_stop: assert property (p_stop) else $error("Sync after halt");

  property p_clat;
    (mode_i == MD_ENC_BL) && coefficient_bus_sync_i |->
      ##81 ((mode_i != MD_ENC_BL) || coefficient_block_sync_o);
  endproperty
  a_clat: assert property (p_clat) else $error("Coefficient delay wrong");

  property p_coefficient_block_sync;
    (mode_i == MD_DEC_BL) && coefficient_bus_sync_i |=> coefficient_block_sync_o;
  endproperty
  a_coefficient_block_sync: assert property (p_coefficient_block_sync) else $error("Coefficient sync lost");

  // Main scenarios
  c_burst: cover property ((mode_i == MD_DEC_BL) && block_sync_o ##65 block_sync_o);
  c_halt: cover property ((mode_i == MD_ENC_BL) && halt_o);
  c_pv: cover property ((mode_i == MD_DEC_PV) && end_of_scan_o);
  c_ll: cover property ((mode_i == MD_DEC_LL) && dec_hold_o ##1 !block_sync_o);
endmodule

// >>> rtl/ispc_pkg.sv
// Constants and types for the image sample port
package ispc_pkg;
  localparam int PIX_W = 12;
  localparam int BLK_LEN = 64;
  localparam int BL_ENC_BITS = 8;
  localparam int PV_BITS = 11;
  localparam logic [2:0] HALT_BUFS = 3'h3;
  localparam int HALT_LEAD = 24;
  localparam int ENC_COEFFICIENT_BUS_LAT = 81;
  localparam int DEC_COEFFICIENT_BUS_LEAD = 80;
  localparam int DLY_DEPTH = ENC_COEFFICIENT_BUS_LAT - 1;
  localparam int ENC_TAP = ENC_COEFFICIENT_BUS_LAT - 2;
  localparam int DEC_TAP = DEC_COEFFICIENT_BUS_LEAD - 2;
  localparam logic [5:0] LAST_IDX = 6'(BLK_LEN - 1);
  localparam logic [5:0] EARLY_IDX = 6'(BLK_LEN - HALT_LEAD);
  localparam logic [3:0] PREC_FULL = 4'hC;

  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_ENC_BL = 3'b001,
    MD_DEC_BL = 3'b010,
    MD_DEC_PV = 3'b011,
    MD_ENC_LL = 3'b100,
    MD_DEC_LL = 3'b101
  } ispc_mode_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_DATA = 1'b1
  } ispc_st_t;

  typedef struct packed {
    ispc_st_t st;
    logic [5:0] idx;
    logic early;
    logic grant;
    logic [2:0] pend;
    logic hold;
    logic [PIX_W-1:0] pix;
    logic dec_oe_n;
    logic bsync;
    logic end_of_scan;
    logic lastp;
    logic halt;
    logic halt_oe_n;
    logic sync_d;
    logic [PIX_W-1:0] enc_data;
    logic enc_vld;
    logic enc_eos;
    logic take;
    logic [PIX_W-1:0] stg;
    logic stgv;
    logic stg_last;
    logic [PIX_W-1:0] coefficient_bus;
    logic coefficient_block_sync;
    logic cvld;
    logic [DLY_DEPTH-1:0][PIX_W+1:0] dly;
  } ispc_state_t;
endpackage

// >>> sim/ispc_fbm.sv
// Model of the external frame buffer controller on the sample port
`timescale 1ns/1ps
module ispc_fbm
  import ispc_pkg::*;
(
  input wire logic halt_i,
  input wire ispc_pkg::ispc_mode_t mode_i,
  output logic [ispc_pkg::PIX_W-1:0] pix_o,
  output logic sync_o,
  output logic eos_o,
  output logic halt_req_o
);
  // Lines start quiet
  initial
  begin
    pix_o = 12'h000;
    sync_o = 1'b0;
    eos_o = 1'b0;
    halt_req_o = 1'b0;
  end
  // One encode cycle; a lossless halt drops sync at once
  task automatic send(input logic s, input logic [PIX_W-1:0] p, input logic e);
    sync_o = s & ~(halt_i & (mode_i == MD_ENC_LL));
    pix_o = p;
    eos_o = e;
  endtask
  // Idle cycle: bus shows the inverse of its last value
  task automatic idle();
    sync_o = 1'b0;
    eos_o = 1'b0;
    pix_o = ~pix_o;
  endtask
  // Halt request towards a decoding device
  task automatic stop(input logic v);
    halt_req_o = v;
  endtask
endmodule

// >>> sim/ispc_pixel_port_bench.sv
// Self-checking bench for the image sample port
`timescale 1ns/1ps
module ispc_pixel_port_bench;
  import ispc_pkg::*;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  ispc_mode_t mode_i = MD_IDLE;
  logic [3:0] precision_i = 4'h0;
  logic [2:0] bufs_used_i = 3'h0;
  logic [PIX_W-1:0] dec_sample_i = 12'h000;
  logic [PIX_W-1:0] coefficient_bus_i = 12'h000;
  logic dec_vld_i = 1'b0;
  logic dec_last_i = 1'b0;
  logic coefficient_bus_sync_i = 1'b0;
  logic coefficient_bus_vld_i = 1'b0;
  logic [PIX_W-1:0] pixel_i, pixel_o, enc_data_o, coefficient_bus_o;
  logic block_sync_i, end_of_scan_i, halt_i, pixel_oe_n_o, block_sync_o;
  logic block_sync_oe_n_o, end_of_scan_o, end_of_scan_oe_n_o, halt_o, halt_oe_n_o;
  logic enc_vld_o, enc_eos_o, dec_take_o, dec_hold_o;
  logic coefficient_block_sync_o, coefficient_vld_o;
  int n_mismatch = 0;
  int tests_run = 0;

  // 40 MHz clock
  always #12.5 core_clk_i = ~core_clk_i;

  ispc_pixel_port ispc_pixel_port_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .mode_i(mode_i),
    .precision_i(precision_i), .pixel_i(pixel_i), .pixel_o(pixel_o),
    .pixel_oe_n_o(pixel_oe_n_o), .block_sync_i(block_sync_i),
    .block_sync_o(block_sync_o), .block_sync_oe_n_o(block_sync_oe_n_o),
    .end_of_scan_i(end_of_scan_i), .end_of_scan_o(end_of_scan_o),
    .end_of_scan_oe_n_o(end_of_scan_oe_n_o), .halt_i(halt_i), .halt_o(halt_o),
    .halt_oe_n_o(halt_oe_n_o), .bufs_used_i(bufs_used_i), .enc_data_o(enc_data_o),
    .enc_vld_o(enc_vld_o), .enc_eos_o(enc_eos_o), .dec_sample_i(dec_sample_i),
    .dec_vld_i(dec_vld_i), .dec_last_i(dec_last_i), .dec_take_o(dec_take_o),
    .dec_hold_o(dec_hold_o), .coefficient_bus_i(coefficient_bus_i), .coefficient_bus_sync_i(coefficient_bus_sync_i),
    .coefficient_bus_vld_i(coefficient_bus_vld_i), .coefficient_bus_o(coefficient_bus_o),
    .coefficient_block_sync_o(coefficient_block_sync_o),
    .coefficient_vld_o(coefficient_vld_o)
  );

  ispc_fbm ispc_fbm_inst (
    .halt_i(halt_o), .mode_i(mode_i), .pix_o(pixel_i), .sync_o(block_sync_i),
    .eos_o(end_of_scan_i), .halt_req_o(halt_i)
  );

  // Wait n edges, then step clear of them
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Sample pattern with busy low bits
  function automatic logic [11:0] pv(input int k);
    return {k[5:0], ~k[5:0]};
  endfunction

  // Switch mode and check pin directions
  task automatic setmode(input ispc_mode_t m, input logic [3:0] pr);
    mode_i = m;
    precision_i = pr;
    tick(2);
    chk("pix_oe_n", pixel_oe_n_o, !(m inside {MD_DEC_BL, MD_DEC_PV, MD_DEC_LL}));
    chk("halt_oe_n", halt_oe_n_o, !(m inside {MD_ENC_BL, MD_ENC_LL}));
    chk("sync_oe_n", block_sync_oe_n_o, !(m inside {MD_DEC_BL, MD_DEC_PV, MD_DEC_LL}));
    chk("eos_oe_n", end_of_scan_oe_n_o, !(m inside {MD_DEC_BL, MD_DEC_PV, MD_DEC_LL}));
  endtask

  // Block encode: capture, end-of-scan, coefficient delay, halt
  task automatic blk_enc();
    setmode(MD_ENC_BL, 4'h0);
    for (int i = 0; i < 100; i++)
    begin
      if (i == 0)
        ispc_fbm_inst.send(1'b1, 12'h000, 1'b0);
      else if (i <= 64)
        ispc_fbm_inst.send(1'b0, pv(i), i == 64);
      else
        ispc_fbm_inst.idle();
      coefficient_bus_sync_i = (i == 0);
      coefficient_bus_vld_i = (i < 64);
      coefficient_bus_i = 12'(i + 1);
      tick(1);
      chk("enc_vld", enc_vld_o, i >= 1 && i <= 64);
      chk("enc_eos", enc_eos_o, i == 64);
      if (i >= 1 && i <= 64)
        chk("enc_data", enc_data_o, {pv(i) & 12'hFF0});
      chk("coefficient_block_sync", coefficient_block_sync_o, i == 80);
      chk("cvld", coefficient_vld_o, i >= 80);
      if (i == 80)
        chk("coefficient_bus_dc", coefficient_bus_o, 12'h001);
    end
    coefficient_bus_vld_i = 1'b0;
    bufs_used_i = 3'h3;
    tick(1);
    chk("halt_on", halt_o, 1'b1);
    bufs_used_i = 3'h2;
    tick(1);
    chk("halt_off", halt_o, 1'b0);
  endtask

  // Block decode: coefficients lead output by 80 clocks; an early halt holds back block two
  task automatic blk_dec();
    setmode(MD_DEC_BL, 4'h0);
    dec_sample_i = 12'h5A3;
    for (int i = 0; i < 227; i++)
    begin
      coefficient_bus_sync_i = (i == 0) || (i == 64);
      coefficient_bus_vld_i = (i < 128);
      coefficient_bus_i = 12'(i + 7);
      dec_last_i = (i >= 150);
      ispc_fbm_inst.stop(i >= 100 && i < 160);
      tick(1);
      chk("coefficient_block_sync", coefficient_block_sync_o, i == 0 || i == 64);
      chk("cvld", coefficient_vld_o, i < 128);
      chk("bsync_out", block_sync_o, i == 79 || i == 160);
      chk("take", dec_take_o, (i >= 80 && i <= 143) || (i >= 161 && i <= 224));
      chk("eos_out", end_of_scan_o, i == 225);
      if (i == 0 || i == 64)
        chk("coefficient_bus_dc", coefficient_bus_o, 12'(i + 7));
      if ((i >= 80 && i <= 143) || (i >= 161 && i <= 224))
        chk("pix_out", pixel_o, 12'h5A3);
    end
    dec_last_i = 1'b0;
  endtask

  // Stream decode: back-to-back samples, formatting, end-of-scan, halt
  task automatic sdec(input ispc_mode_t m, input logic [3:0] pr, input logic [11:0] e0,
                      input logic [11:0] e1);
    setmode(m, pr);
    for (int i = 0; i < 6; i++)
    begin
      dec_vld_i = (i < 2);
      dec_sample_i = (i == 0) ? 12'hFFF : 12'h555;
      dec_last_i = (i == 1);
      tick(1);
      chk("ssync", block_sync_o, i == 0 || i == 1);
      chk("seos", end_of_scan_o, i == 3);
      if (i == 1 || i == 2)
        chk("spix", pixel_o, (i == 1) ? e0 : e1);
    end
    if (m == MD_DEC_LL)
    begin
      ispc_fbm_inst.stop(1'b1);
      tick(1);
      chk("hold", dec_hold_o, 1'b1);
      dec_vld_i = 1'b1;
      repeat (3)
      begin
        tick(1);
        dec_vld_i = 1'b0;
        chk("halted_sync", block_sync_o, 1'b0);
      end
      ispc_fbm_inst.stop(1'b0);
    end
  endtask

  // Lossless encode: masking, end-of-scan, halt response
  task automatic ll_enc();
    setmode(MD_ENC_LL, 4'h6);
    for (int i = 0; i < 4; i++)
    begin
      ispc_fbm_inst.send(i < 2, (i == 1) ? 12'hFFF : 12'h0A5, i == 2);
      tick(1);
      chk("ll_vld", enc_vld_o, i == 1 || i == 2);
      chk("ll_eos", enc_eos_o, i == 2);
      if (i == 1 || i == 2)
        chk("ll_data", enc_data_o, (i == 1) ? 12'hFC0 : 12'h080);
    end
    bufs_used_i = 3'h3;
    tick(1);
    chk("ll_halt", halt_o, 1'b1);
    ispc_fbm_inst.send(1'b1, 12'hFFF, 1'b0);
    repeat (3)
    begin
      tick(1);
      ispc_fbm_inst.idle();
      chk("ll_stopped", enc_vld_o, 1'b0);
    end
    bufs_used_i = 3'h0;
  endtask

  // Main sequence
  initial
  begin
    tick(16);
    chk("rst_oe", pixel_oe_n_o, 1'b1);
    nrst_i = 1'b1;
    blk_enc();
    blk_dec();
    sdec(MD_DEC_PV, 4'h0, 12'hFFE, 12'hAAA);
    sdec(MD_DEC_LL, 4'h8, 12'hFF0, 12'h550);
    ll_enc();
    tally_and_finish();
  end
endmodule
